/* File: include/dwts_pkg.sv */
// Shared constants, types and helpers for the dual wiper two-wire link
package dwts_pkg;

  // Wiper register width and the two end positions
  localparam int WIPER_W = 8;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] WIPER_HIGH_END = 8'hFF;
  localparam logic [7:0] WIPER_LOW_END = 8'h00;

  // Device-type code in the address byte; value is arbitrary
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;

  // Address byte field positions
  localparam int ADDR_TYPE_MSB = 7;
  localparam int ADDR_TYPE_LSB = 4;
  localparam int ADDR_SEL_MSB = 3;
  localparam int ADDR_SEL_LSB = 1;
  localparam int ADDR_RW_BIT = 0;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // Command byte values
  localparam logic [7:0] CMD_WR_FIRST = 8'hA9;
  localparam logic [7:0] CMD_WR_SECOND = 8'hAA;
  localparam logic [7:0] CMD_WR_BOTH = 8'hAF;

  // Bit slot numbers inside one byte frame
  localparam logic [3:0] SLOT_LAST_BIT = 4'h7;
  localparam logic [3:0] SLOT_ACK = 4'h8;

  // Serial clock timing: quarter period, least time, rounded up
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int SCL_QUARTER_CYC =
    (SCL_QUARTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYC - 1);

  // Device link states
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_ADDR = 5'b00010,
    D_CMD = 5'b00100,
    D_DATA = 5'b01000,
    D_TX = 5'b10000
  } dwts_dstate_t;

  // Master sequencer states
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_START = 4'b0010,
    M_BIT = 4'b0100,
    M_STOP = 4'b1000
  } dwts_mstate_t;

  // Builds an address byte from select straps and direction
  function automatic logic [7:0] dwts_addr_byte(input logic [2:0] sel,
                                                input logic rd);
    dwts_addr_byte = {DEV_TYPE_CODE, sel, rd};
  endfunction

  // True when an address byte names this device
  function automatic logic dwts_addr_match(input logic [7:0] b,
                                           input logic [2:0] sel);
    dwts_addr_match =
      (b[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEV_TYPE_CODE) &&
      (b[ADDR_SEL_MSB:ADDR_SEL_LSB] == sel);
  endfunction

endpackage

/* File: include/dwts_link_if.sv */
// Two-wire link between the bus master and the wiper device
`timescale 1ns/1ps
`default_nettype none
interface dwts_link_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic sda;

  // Open-drain data line with pull-up: low when any end drives low
  assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

  modport master (
    output scl,
    output m_sda_out,
    output m_sda_oe,
    input sda
  );

  modport device (
    input scl,
    output d_sda_out,
    output d_sda_oe,
    input sda
  );
endinterface
`default_nettype wire

/* File: design/dwts_device.sv */
// Dual wiper two-wire slave: link logic on the bus clock, wipers out
// How it works
// - Two 8-bit wiper registers, FFh high end
// - Both wipers clear to 00h at reset
// - Three straps matched against address select bits
// - Master makes every clock, START and STOP
// - Master starts only when both lines high
// - Data changes only while clock is low
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Bytes of eight clocks plus acknowledge slot
// - Acknowledger holds data low through ninth clock
// - Master nacks last read byte, device releases
// - Write: address then data, device acks each
// - Master acks read bytes except the last
// - Master alone sets byte count, no limit; dwts_master ends after four bytes at most, address included
// - STOP or repeated START ends a transfer
// - Address match then receive or transmit by direction
// - START begins, STOP ends, in both roles
// - Address: type code, selects, direction bit
// - All bytes most significant bit first
// - Read returns first wiper then second wiper
// - Commands write first, second, or both wipers
`timescale 1ns/1ps
`default_nettype none
module dwts_device
  import dwts_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  dwts_link_if.device link,
  input wire logic [2:0] bus_select_straps,
  output logic [7:0] first_wiper_terminal,
  output logic [7:0] second_wiper_terminal
);

  // Condition detectors, clocked by data line edges
  logic start_tog;
  logic stop_tog;
  // Link domain, clocked by the serial clock
  logic start_seen;
  logic stop_seen;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic rx_bit;
  dwts_dstate_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] cmd;
  logic [7:0] txsh;
  logic [1:0] didx;
  logic rw;
  logic addr_ok;
  logic tx_second;
  logic sda_oe;
  logic [7:0] wiper0;
  logic [7:0] wiper1;
  logic upd_tog;
  // Local clock domain
  logic upd_s1;
  logic upd_s2;
  logic upd_s3;

  logic start_pend;
  logic stop_pend;
  logic [7:0] next_byte;
  logic wr_now;

  // Falling data while clock high marks a START
  always_ff @(negedge link.sda or negedge arst_n) begin
    if (!arst_n) begin
      start_tog <= 1'b0;
    end else if (link.scl) begin
      start_tog <= ~start_tog;
    end
  end

  // Rising data while clock high marks a STOP
  always_ff @(posedge link.sda or negedge arst_n) begin
    if (!arst_n) begin
      stop_tog <= 1'b0;
    end else if (link.scl) begin
      stop_tog <= ~stop_tog;
    end
  end

  // Pending conditions are consumed at the next falling clock edge
  assign start_pend = start_tog ^ start_seen;
  assign stop_pend = stop_tog ^ stop_seen;
  // Serial bytes shift in most significant bit first
  assign next_byte = {shreg[6:0], rx_bit};
  // Eighth data bit of a data byte has just completed
  assign wr_now = (state == D_DATA) && !start_pend && !stop_pend &&
                  (cnt == SLOT_LAST_BIT);

  // Strap pins pass two flops before the address compare
  always_ff @(negedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else begin
      strap_s1 <= bus_select_straps;
      strap_s2 <= strap_s1;
    end
  end

  // Data is sampled while the clock is high
  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      rx_bit <= 1'b1;
    end else begin
      rx_bit <= link.sda;
    end
  end

  // Frame sequencer; the data line is driven only on falling clock
  always_ff @(negedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      state <= D_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      txsh <= 8'h00;
      didx <= 2'h0;
      rw <= DIR_WRITE;
      addr_ok <= 1'b0;
      tx_second <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_pend) begin
      // START or repeated START opens a new frame
      start_seen <= start_tog;
      stop_seen <= stop_tog;
      state <= D_ADDR;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_pend) begin
      stop_seen <= stop_tog;
      state <= D_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        D_ADDR, D_CMD, D_DATA: begin
          if (cnt != SLOT_ACK) begin
            shreg <= next_byte;
            cnt <= cnt + 4'h1;
            if (cnt == SLOT_LAST_BIT) begin
              // Ack every data byte, address only on a match
              sda_oe <= (state != D_ADDR) ||
                        dwts_addr_match(next_byte, strap_s2);
              if (state == D_ADDR) begin
                addr_ok <= dwts_addr_match(next_byte, strap_s2);
                rw <= next_byte[ADDR_RW_BIT];
              end
              if (state == D_CMD) begin
                cmd <= next_byte;
              end
            end
          end else begin
            // End of acknowledge slot: release and pick the role
            cnt <= 4'h0;
            sda_oe <= 1'b0;
            if (state == D_ADDR) begin
              if (!addr_ok) begin
                state <= D_IDLE;
              end else if (rw == DIR_READ) begin
                state <= D_TX;
                txsh <= wiper0;
                sda_oe <= ~wiper0[7];
                tx_second <= 1'b1;
              end else begin
                state <= D_CMD;
              end
            end else if (state == D_CMD) begin
              state <= D_DATA;
              didx <= 2'h0;
            end else if (didx != 2'h3) begin
              didx <= didx + 2'h1;
            end
          end
        end
        D_TX: begin
          if (cnt < SLOT_LAST_BIT) begin
            txsh <= {txsh[6:0], 1'b0};
            sda_oe <= ~txsh[6];
            cnt <= cnt + 4'h1;
          end else if (cnt == SLOT_LAST_BIT) begin
            // Free the line for the master's acknowledge
            sda_oe <= 1'b0;
            cnt <= SLOT_ACK;
          end else if (rx_bit) begin
            // Master did not acknowledge: stay released
            state <= D_IDLE;
            sda_oe <= 1'b0;
            cnt <= 4'h0;
          end else begin
            // Acknowledged: send the other wiper next
            txsh <= tx_second ? wiper1 : wiper0;
            sda_oe <= tx_second ? ~wiper1[7] : ~wiper0[7];
            tx_second <= ~tx_second;
            cnt <= 4'h0;
          end
        end
        D_IDLE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state <= D_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Wiper registers, written by the command then data bytes
  always_ff @(negedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      wiper0 <= WIPER_RESET;
      wiper1 <= WIPER_RESET;
      upd_tog <= 1'b0;
    end else if (wr_now) begin
      upd_tog <= ~upd_tog;
      case (cmd)
        CMD_WR_FIRST: begin
          if (didx == 2'h0) begin
            wiper0 <= next_byte;
          end else if (didx == 2'h1) begin
            wiper1 <= next_byte;
          end
        end
        CMD_WR_SECOND: begin
          if (didx == 2'h0) begin
            wiper1 <= next_byte;
          end
        end
        CMD_WR_BOTH: begin
          if (didx == 2'h0) begin
            wiper0 <= next_byte;
            wiper1 <= next_byte;
          end
        end
        default: begin
          wiper0 <= wiper0;
        end
      endcase
    end
  end

  // Open-drain drive: only ever pulls low
  assign link.d_sda_out = 1'b0;
  assign link.d_sda_oe = sda_oe;

  // Update toggle crosses by two flops; wipers are stable meanwhile
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upd_s1 <= 1'b0;
      upd_s2 <= 1'b0;
      upd_s3 <= 1'b0;
    end else begin
      upd_s1 <= upd_tog;
      upd_s2 <= upd_s1;
      upd_s3 <= upd_s2;
    end
  end

  // Wiper outputs copy the link registers after each write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      first_wiper_terminal <= WIPER_RESET;
      second_wiper_terminal <= WIPER_RESET;
    end else if (upd_s2 ^ upd_s3) begin
      first_wiper_terminal <= wiper0;
      second_wiper_terminal <= wiper1;
    end
  end

endmodule
`default_nettype wire

/* File: design/dwts_master.sv */
// Two-wire bus master that writes and reads the wiper device
`timescale 1ns/1ps
`default_nettype none
module dwts_master
  import dwts_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  dwts_link_if.master link,
  input wire logic xfer_start,
  input wire logic xfer_read,
  input wire logic [2:0] dev_select,
  input wire logic [1:0] xfer_len,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] wr_data0,
  input wire logic [7:0] wr_data1,
  output logic busy,
  output logic xfer_done,
  output logic ack_missing,
  output logic [7:0] rd_data0,
  output logic [7:0] rd_data1
);

  dwts_mstate_t state;
  logic [7:0] qcnt;
  logic [1:0] q;
  logic tick;
  logic sda_s1;
  logic sda_s2;
  logic rd;
  logic [1:0] len;
  logic [2:0] sel;
  logic [7:0] b_cmd;
  logic [7:0] b_d0;
  logic [7:0] b_d1;
  logic [1:0] bi;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic ack_bit;
  logic scl;
  logic sda_oe;
  logic tx;

  assign tick = (qcnt == QUARTER_LAST);
  assign tx = (bi == 2'h0) || !rd;

  // Data line input passes two flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  // Quarter-period divider, held still while idle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      qcnt <= 8'h00;
      q <= 2'h0;
    end else if (state == M_IDLE) begin
      qcnt <= 8'h00;
      q <= 2'h0;
    end else if (tick) begin
      qcnt <= 8'h00;
      q <= q + 2'h1;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // Sequencer: START, bytes of nine clocks, STOP
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= M_IDLE;
      scl <= 1'b1;
      sda_oe <= 1'b0;
      busy <= 1'b0;
      xfer_done <= 1'b0;
      ack_missing <= 1'b0;
      rd <= 1'b0;
      len <= 2'h0;
      sel <= 3'h0;
      b_cmd <= 8'h00;
      b_d0 <= 8'h00;
      b_d1 <= 8'h00;
      bi <= 2'h0;
      cnt <= 4'h0;
      sh <= 8'h00;
      ack_bit <= 1'b1;
      rd_data0 <= 8'h00;
      rd_data1 <= 8'h00;
    end else begin
      xfer_done <= 1'b0;
      case (state)
        M_IDLE: begin
          scl <= 1'b1;
          sda_oe <= 1'b0;
          if (xfer_start) begin
            // Both lines are high here, so the bus is idle
            state <= M_START;
            busy <= 1'b1;
            ack_missing <= 1'b0;
            rd <= xfer_read;
            len <= xfer_len;
            sel <= dev_select;
            b_cmd <= cmd_byte;
            b_d0 <= wr_data0;
            b_d1 <= wr_data1;
          end
        end
        M_START: begin
          if (tick) begin
            case (q)
              2'h0: scl <= 1'b1;
              2'h1: sda_oe <= 1'b1;
              2'h2: scl <= 1'b0;
              default: begin
                state <= M_BIT;
                bi <= 2'h0;
                cnt <= 4'h0;
                sh <= dwts_addr_byte(sel, rd);
              end
            endcase
          end
        end
        M_BIT: begin
          if (tick) begin
            case (q)
              2'h0: begin
                // Change data only while the clock is low
                if (cnt != SLOT_ACK) begin
                  sda_oe <= tx & ~sh[7];
                end else begin
                  sda_oe <= !tx && (bi != len);
                end
              end
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (cnt != SLOT_ACK) begin
                  sh <= {sh[6:0], sda_s2};
                end else begin
                  ack_bit <= sda_s2;
                end
              end
              default: begin
                scl <= 1'b0;
                if (cnt != SLOT_ACK) begin
                  cnt <= cnt + 4'h1;
                end else begin
                  cnt <= 4'h0;
                  if (!tx && bi == 2'h1) begin
                    rd_data0 <= sh;
                  end
                  if (!tx && bi == 2'h2) begin
                    rd_data1 <= sh;
                  end
                  if (tx && ack_bit) begin
                    ack_missing <= 1'b1;
                    state <= M_STOP;
                  end else if (bi == len) begin
                    state <= M_STOP;
                  end else begin
                    bi <= bi + 2'h1;
                    case (bi)
                      2'h0: sh <= rd ? 8'hFF : b_cmd;
                      2'h1: sh <= rd ? 8'hFF : b_d0;
                      default: sh <= rd ? 8'hFF : b_d1;
                    endcase
                  end
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            case (q)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe <= 1'b0;
              default: begin
                state <= M_IDLE;
                busy <= 1'b0;
                xfer_done <= 1'b1;
              end
            endcase
          end
        end
        default: begin
          state <= M_IDLE;
        end
      endcase
    end
  end

  // Master drives the clock; data line is open drain
  assign link.scl = scl;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe = sda_oe;

endmodule
`default_nettype wire

/* File: bench/dwts_link_properties.sv */
// Concurrent checks on the two-wire link between master and device
`timescale 1ns/1ps
`default_nettype none
module dwts_link_properties
  import dwts_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic m_sda_oe,
  input wire logic d_sda_oe,
  input wire logic sda,
  input wire logic [2:0] straps
);
  localparam int HI = 2 * SCL_QUARTER_CYC;
  logic scl_q, sda_q, idle, nacked, missed;
  logic rise, fall, start, stop;
  logic [3:0] bitn;
  logic [1:0] byten;
  logic [7:0] addr;
  logic [9:0] hi_cnt;

  // Edge and bus condition decode
  assign rise = scl & ~scl_q;
  assign fall = ~scl & scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;

  // Delayed copies of both lines
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Slot and byte position inside a frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bitn <= 4'hF;
      byten <= 2'h0;
    end else if (start) begin
      bitn <= 4'hF;
      byten <= 2'h0;
    end else if (fall) begin
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (bitn == 4'h8 && byten != 2'h3) begin
        byten <= byten + 2'h1;
      end
    end
  end

  // Address capture and frame flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr <= 8'h00;
      nacked <= 1'b0;
      missed <= 1'b0;
      idle <= 1'b1;
    end else begin
      if (rise && byten == 2'h0 && bitn < 4'h8) begin
        addr <= {addr[6:0], sda};
      end
      if (start) begin
        nacked <= 1'b0;
        missed <= 1'b0;
        idle <= 1'b0;
      end
      if (stop) begin
        idle <= 1'b1;
      end
      if (rise && bitn == 4'h8 && sda && byten == 2'h0) begin
        missed <= 1'b1;
      end
      if (rise && bitn == 4'h8 && sda && byten != 2'h0) begin
        nacked <= addr[0] == DIR_READ;
      end
    end
  end

  // Length of each clock high phase
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt <= 10'h000;
    end else if (!scl) begin
      hi_cnt <= 10'h000;
    end else if (hi_cnt != 10'h3FF) begin
      hi_cnt <= hi_cnt + 10'h001;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_dev_data_steady:
    assert property (scl && scl_q |-> $stable(d_sda_oe))
    else $error("device data moved while clock high");
  a_dev_moves_low:
    assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device data changed with clock high");
  a_bit_high_len:
    assert property (fall && bitn != 4'hF |-> hi_cnt == HI)
    else $error("clock high phase has wrong length");
  a_addr_not_driven:
    assert property (scl && byten == 2'h0 && bitn < 4'h8 |-> !d_sda_oe)
    else $error("device drove during address bits");
  a_ack_type_code:
    assert property (scl && byten == 2'h0 && bitn == 4'h8 && d_sda_oe
      |-> addr[7:1] == {DEV_TYPE_CODE, straps})
    else $error("device acked a foreign address");
  a_ack_master_free:
    assert property (scl && d_sda_oe && bitn == 4'h8 |-> !m_sda_oe)
    else $error("master drove in device ack slot");
  a_quiet_after_nack:
    assert property (nacked && scl |-> !d_sda_oe)
    else $error("device drove after read nack");
  a_quiet_when_idle:
    assert property (idle |-> !d_sda_oe)
    else $error("device drove outside a frame");
  a_quiet_after_miss:
    assert property (missed |-> !d_sda_oe)
    else $error("device drove after address mismatch");
  a_stop_on_byte:
    assert property (stop |-> bitn == 4'h0)
    else $error("stop inside a byte");
  a_start_when_idle:
    assert property (start |-> idle)
    else $error("start issued while bus busy");

  c_addr_acked: cover property (scl && byten == 2'h0 && bitn == 4'h8
    && d_sda_oe);
  c_read_nack: cover property (nacked && stop);
  c_addr_missed: cover property (missed && stop);
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench: master and wiper device joined on one link
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dwts_pkg::*;
;
  logic clock, arst_n, xfer_start, xfer_read, busy, xfer_done, ack_missing;
  logic [2:0] straps, dev_select;
  logic [1:0] xfer_len;
  logic [7:0] cmd_byte, wr_data0, wr_data1, rd_data0, rd_data1;
  logic [7:0] pot_first, pot_second;
  logic [7:0] c, d0, d1;
  integer seed, n_mismatch, num_checks, m0, m1, i;

  dwts_link_if link_bus();
  dwts_master i_dwts_master(.clock(clock), .arst_n(arst_n),
    .link(link_bus), .xfer_start(xfer_start), .xfer_read(xfer_read),
    .dev_select(dev_select), .xfer_len(xfer_len), .cmd_byte(cmd_byte),
    .wr_data0(wr_data0), .wr_data1(wr_data1), .busy(busy),
    .xfer_done(xfer_done), .ack_missing(ack_missing),
    .rd_data0(rd_data0), .rd_data1(rd_data1));
  dwts_device i_dwts_device(.clock(clock), .arst_n(arst_n),
    .link(link_bus), .bus_select_straps(straps),
    .first_wiper_terminal(pot_first),
    .second_wiper_terminal(pot_second));
  dwts_link_properties i_dwts_link_properties(.clock(clock),
    .arst_n(arst_n), .scl(link_bus.scl), .m_sda_oe(link_bus.m_sda_oe),
    .d_sda_oe(link_bus.d_sda_oe), .sda(link_bus.sda), .straps(straps));

  // Local clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Compares one value and counts it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One transfer, with a refused request while busy
  task automatic xfer(input logic rd, input logic [2:0] sel,
    input logic [1:0] len, input logic [7:0] cb, b0, b1);
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    #1;
    xfer_read = rd;
    dev_select = sel;
    xfer_len = len;
    cmd_byte = cb;
    wr_data0 = b0;
    wr_data1 = b1;
    xfer_start = 1'b1;
    @(posedge clock);
    #1;
    xfer_start = 1'b0;
    check({7'h00, busy}, 8'h01);
    for (int k = 0; k < 30000 && !seen; k++) begin
      @(posedge clock);
      #1;
      if (k == 5) begin
        xfer_start = 1'b1;
        xfer_read = ~rd;
      end
      if (k == 6) begin
        xfer_start = 1'b0;
      end
      if (xfer_done === 1'b1) begin
        seen = 1'b1;
        check({7'h00, busy}, 8'h00);
      end
    end
    if (!seen) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
    repeat (8) @(posedge clock);
    #1;
  endtask

  // Wiper model update for one write
  task automatic model(input logic [7:0] cb, input logic [1:0] len,
    input logic [7:0] b0, b1);
    if (cb == CMD_WR_FIRST && len >= 2'h2) m0 = b0;
    if (cb == CMD_WR_FIRST && len == 2'h3) m1 = b1;
    if (cb == CMD_WR_SECOND && len >= 2'h2) m1 = b0;
    if (cb == CMD_WR_BOTH && len >= 2'h2) begin
      m0 = b0;
      m1 = b0;
    end
  endtask

  // Main sequence
  initial begin
    seed = 33044;
    n_mismatch = 0;
    num_checks = 0;
    m0 = 0;
    m1 = 0;
    arst_n = 1'b0;
    xfer_start = 1'b0;
    xfer_read = 1'b0;
    dev_select = 3'h0;
    xfer_len = 2'h0;
    cmd_byte = 8'h00;
    wr_data0 = 8'h00;
    wr_data1 = 8'h00;
    straps = 3'($random(seed));
    repeat (4) @(posedge clock);
    #1;
    arst_n = 1'b1;
    check(pot_first, 8'h00);
    check(pot_second, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      c = (i == 0) ? CMD_WR_FIRST : (i == 1) ? CMD_WR_BOTH : CMD_WR_SECOND;
      if (i == 3) begin
        c = 8'($random(seed));
      end
      if (i == 3 && (c == CMD_WR_FIRST || c == CMD_WR_SECOND
          || c == CMD_WR_BOTH)) begin
        c = c ^ 8'h01;
      end
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      // The both-wipers write also carries one excess data byte
      xfer(1'b0, straps, (i < 2) ? 2'h3 : 2'h2, c, d0, d1);
      model(c, (i < 2) ? 2'h3 : 2'h2, d0, d1);
      check({7'h00, ack_missing}, 8'h00);
      check(pot_first, m0[7:0]);
      check(pot_second, m1[7:0]);
      $display("test write %0d done", i);
    end
    xfer(1'b1, straps, 2'h2, 8'h00, 8'h00, 8'h00);
    check(rd_data0, m0[7:0]);
    check(rd_data1, m1[7:0]);
    check({7'h00, ack_missing}, 8'h00);
    $display("test read done");
    xfer(1'b0, straps ^ 3'h5, 2'h1, CMD_WR_BOTH, 8'h00, 8'h00);
    check({7'h00, ack_missing}, 8'h01);
    check(pot_first, m0[7:0]);
    check(pot_second, m1[7:0]);
    $display("test mismatch done");
    complete_run();
  end
endmodule
`default_nettype wire
